// ===== verilog/key_scanner.sv
// autonomous key matrix scanner with ghost lockout and code buffer
module key_scanner #(
    parameter int NMOD = kscan_pkg::NUM_MODS,
    parameter int DEPTH = kscan_pkg::BUF_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // configuration
    input wire logic scan_en,
    input wire logic [kscan_pkg::COL_W-1:0] num_cols,
    input wire logic [3:0] num_rows,
    input wire logic [NMOD-1:0][kscan_pkg::CODE_W-1:0] mod_code,
    // matrix pins
    input wire logic [kscan_pkg::MAX_ROWS-1:0] row_in,
    output logic [kscan_pkg::MAX_COLS-1:0] col_out,
    // shared low-power clock request
    output logic lp_clk_req,
    // key code buffer read side
    output logic key_valid,
    input wire logic key_pop,
    output logic [kscan_pkg::CODE_W-1:0] key_code,
    // status
    output logic scan_busy,
    output logic ghost_flag,
    input wire logic ghost_clr,
    output logic ovf_flag,
    input wire logic ovf_clr,
    output logic [NMOD-1:0] mod_state
);
    import kscan_pkg::*;

    scan_state_t state_q, state_d;
    logic req_q, req_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic tick;
    logic [ROW_W-1:0] row_q, row_d;
    logic [COL_W-1:0] col_q, col_d;
    logic settle_q, settle_d;
    logic [CODE_W-1:0] idx_q, idx_d;
    logic [MAX_ROWS-1:0] hit_q, hit_d;
    logic [MAX_ROWS-1:0] colhit_q, colhit_d;
    logic any_q, any_d;
    logic [MAX_KEYS-1:0] pressed_q, pressed_d;
    logic [NMOD-1:0] modnow_q, modnow_d;
    logic [NMOD-1:0] mod_q, mod_d;
    logic ghost_q, ghost_d;
    logic ovf_q, ovf_d;
    logic push_q, push_d;
    logic [CODE_W-1:0] pcode_q, pcode_d;
    logic [MAX_ROWS-1:0] rows_f;
    logic [MAX_ROWS-1:0] prev_q;
    logic [MAX_COLS-1:0] col_q_out, col_d_out;
    logic buf_ready;
    logic [ROW_W-1:0] last_row;
    logic [COL_W-1:0] last_col;
    logic key_hit;
    logic is_ghost;
    logic is_mod;
    logic [NMOD-1:0] mod_match;
    logic row_wrap;

    // debounce and glitch filter ahead of all row logic
    row_filter #(
        .N(MAX_ROWS),
        .STABLE(DEB_CYC)
    ) u_rows (
        .mclk(mclk),
        .nrst(nrst),
        .raw(row_in),
        .clean(rows_f)
    );

    // a full buffer refuses the push; the code is then lost
    code_buffer #(
        .W(CODE_W),
        .DEPTH(DEPTH)
    ) u_buf (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(push_q),
        .in_ready(buf_ready),
        .in_data(pcode_q),
        .out_valid(key_valid),
        .out_ready(key_pop),
        .out_data(key_code)
    );

    // out-of-range counts are clamped rather than trusted
    always_comb begin
        if (num_rows == 4'h0) begin
            last_row = '0;
        end else if (num_rows > 4'h8) begin
            last_row = ROW_W'(MAX_ROWS - 1);
        end else begin
            last_row = ROW_W'(num_rows - 4'h1);
        end
        if (num_cols == '0) begin
            last_col = '0;
        end else if (num_cols > LAST_COL_MAX) begin
            last_col = LAST_COL_MAX;
        end else begin
            last_col = num_cols - 1'b1;
        end
    end

    // scan rate enable; only runs while the clock is requested
    always_comb begin
        div_d = div_q;
        tick = 1'b0;
        if (!req_q) begin
            div_d = '0;
        end else if (div_q == DIV_W'(LPO_DIV - 1)) begin
            div_d = '0;
            tick = 1'b1;
        end else begin
            div_d = div_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // per-position decode of the current key
    always_comb begin
        key_hit = rows_f[row_q];
        is_ghost = key_hit && hit_q[row_q];
        for (int m = 0; m < NMOD; m++) begin
            mod_match[m] = (mod_code[m] == idx_q);
        end
        is_mod = |mod_match;
        row_wrap = (row_q == last_row);
    end

    // main sequencer
    always_comb begin
        state_d = state_q;
        req_d = req_q;
        row_d = row_q;
        col_d = col_q;
        settle_d = settle_q;
        idx_d = idx_q;
        hit_d = hit_q;
        colhit_d = colhit_q;
        any_d = any_q;
        pressed_d = pressed_q;
        modnow_d = modnow_q;
        mod_d = mod_q;
        push_d = 1'b0;
        pcode_d = pcode_q;
        ghost_d = ghost_q;
        ovf_d = ovf_q;
        unique case (state_q)
            ST_IDLE: begin
                req_d = 1'b0;
                idx_d = IDX_RST;
                hit_d = HIT_RST;
                colhit_d = '0;
                row_d = '0;
                col_d = '0;
                settle_d = 1'b1;
                any_d = 1'b0;
                pressed_d = '0;
                mod_d = '0;
                modnow_d = '0;
                if (scan_en && (rows_f != prev_q)) begin
                    req_d = 1'b1;
                    state_d = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (tick && settle_q) begin
                    // column lines need one step to settle
                    settle_d = 1'b0;
                end else if (tick) begin
                    idx_d = idx_q + 1'b1;
                    colhit_d[row_q] = key_hit;
                    if (key_hit) begin
                        any_d = 1'b1;
                    end
                    if (is_ghost) begin
                        ghost_d = 1'b1;
                    end
                    if (key_hit && is_mod) begin
                        modnow_d = modnow_q | mod_match;
                    end
                    if (idx_q < CODE_W'(MAX_KEYS)) begin
                        if (!key_hit) begin
                            pressed_d[idx_q] = 1'b0;
                        end else if (!is_mod && !is_ghost && !pressed_q[idx_q]) begin
                            // ghosted keys stay unreported and retry next pass
                            pressed_d[idx_q] = 1'b1;
                            push_d = 1'b1;
                            pcode_d = idx_q;
                        end
                    end
                    if (row_wrap) begin
                        row_d = '0;
                        // judge the finished column before clearing it for the next
                        if (count_ones(colhit_d) >= 4'h2) begin
                            hit_d = hit_q | colhit_d;
                        end
                        colhit_d = '0;
                        if (col_q == last_col) begin
                            col_d = '0;
                            state_d = ST_END;
                        end else begin
                            col_d = col_q + 1'b1;
                            settle_d = 1'b1;
                        end
                    end else begin
                        row_d = row_q + 1'b1;
                    end
                end
            end
            ST_END: begin
                mod_d = modnow_q;
                modnow_d = '0;
                idx_d = IDX_RST;
                hit_d = HIT_RST;
                settle_d = 1'b1;
                any_d = 1'b0;
                if (any_q) begin
                    state_d = ST_SCAN;
                end else begin
                    state_d = ST_IDLE;
                    req_d = 1'b0;
                end
            end
        endcase
        if (!scan_en) begin
            state_d = ST_IDLE;
            req_d = 1'b0;
            mod_d = '0;
        end
        // a new event wins over a clear in the same cycle
        if (ghost_clr && !(state_q == ST_SCAN && tick && !settle_q && is_ghost)) begin
            ghost_d = 1'b0;
        end
        if (push_q && !buf_ready) begin
            ovf_d = 1'b1;
        end else if (ovf_clr) begin
            ovf_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            req_q <= 1'b0;
            row_q <= '0;
            col_q <= '0;
            settle_q <= 1'b1;
            idx_q <= IDX_RST;
            hit_q <= HIT_RST;
            colhit_q <= '0;
            any_q <= 1'b0;
            pressed_q <= '0;
            modnow_q <= '0;
            mod_q <= '0;
            push_q <= 1'b0;
            pcode_q <= '0;
            ghost_q <= 1'b0;
            ovf_q <= 1'b0;
            prev_q <= '0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            row_q <= row_d;
            col_q <= col_d;
            settle_q <= settle_d;
            idx_q <= idx_d;
            hit_q <= hit_d;
            colhit_q <= colhit_d;
            any_q <= any_d;
            pressed_q <= pressed_d;
            modnow_q <= modnow_d;
            mod_q <= mod_d;
            push_q <= push_d;
            pcode_q <= pcode_d;
            ghost_q <= ghost_d;
            ovf_q <= ovf_d;
            prev_q <= rows_f;
        end
    end

    // idle drives every column high; scanning drives only the active one
    always_comb begin
        col_d_out = {MAX_COLS{1'b1}};
        if (state_d != ST_IDLE) begin
            col_d_out = '0;
            col_d_out[col_d] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            col_q_out <= {MAX_COLS{1'b1}};
        end else begin
            col_q_out <= col_d_out;
        end
    end

    // status is level only; the processor polls it
    assign col_out = col_q_out;
    assign lp_clk_req = req_q;
    assign scan_busy = (state_q != ST_IDLE);
    assign ghost_flag = ghost_q;
    assign ovf_flag = ovf_q;
    assign mod_state = mod_q;
endmodule

// ===== verilog/kscan_pkg.sv
// constants, states and helpers shared by the key matrix scanner
package kscan_pkg;
    localparam int MCLK_HZ = 25_000_000;
    localparam int LPO_HZ = 128_000;
    localparam int LPO_DIV = MCLK_HZ / LPO_HZ;
    localparam int DIV_W = 8;
    localparam int DEB_NS = 5000;
    localparam int DEB_CYC = (DEB_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
    localparam int DEB_W = 8;
    localparam int MAX_ROWS = 8;
    localparam int MAX_COLS = 20;
    localparam int MAX_KEYS = 160;
    localparam int ROW_W = 3;
    localparam int COL_W = 5;
    localparam int CODE_W = 8;
    localparam int BUF_DEPTH = 16;
    localparam int NUM_MODS = 8;
    localparam logic [COL_W-1:0] LAST_COL_MAX = 5'h13;
    localparam logic [CODE_W-1:0] IDX_RST = 8'h00;
    localparam logic [MAX_ROWS-1:0] HIT_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SCAN = 3'b010,
        ST_END = 3'b100
    } scan_state_t;

    function automatic logic [3:0] count_ones(input logic [MAX_ROWS-1:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < MAX_ROWS; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction
endpackage

// ===== verilog/row_filter.sv
// two-stage synchroniser and stability filter for the row inputs
module row_filter #(
    parameter int N = 8,
    parameter int STABLE = 125
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // raw rows and filtered rows
    input wire logic [N-1:0] raw,
    output logic [N-1:0] clean
);
    import kscan_pkg::*;

    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] cand_q, cand_d;
    logic [N-1:0] clean_q, clean_d;
    logic [DEB_W-1:0] cnt_q, cnt_d;

    // any change restarts the count, so a glitch never reaches the scanner
    always_comb begin
        cand_d = cand_q;
        cnt_d = cnt_q;
        clean_d = clean_q;
        if (sync_q != cand_q) begin
            cand_d = sync_q;
            cnt_d = '0;
        end else if (cnt_q != DEB_W'(STABLE - 1)) begin
            cnt_d = cnt_q + 1'b1;
        end else begin
            clean_d = cand_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
            cand_q <= '0;
            cnt_q <= '0;
            clean_q <= '0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
            cand_q <= cand_d;
            cnt_q <= cnt_d;
            clean_q <= clean_d;
        end
    end

    assign clean = clean_q;
endmodule

// ===== verilog/code_buffer.sv
// flip-flop fifo holding key codes until the processor pops them
module code_buffer #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d;
    logic [AW-1:0] rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage needs no reset; the count guards every read
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// ===== bench/key_scanner_asserts.sv
// concurrent checks on the key scanner ports
module scanner_checker #(
    parameter int NMOD = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // watched ports
    input wire logic scan_en,
    input wire logic [19:0] col_out,
    input wire logic lp_clk_req,
    input wire logic key_valid,
    input wire logic key_pop,
    input wire logic scan_busy,
    input wire logic ghost_flag,
    input wire logic ghost_clr,
    input wire logic ovf_flag,
    input wire logic ovf_clr,
    input wire logic [NMOD-1:0] mod_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_DIS_NO_REQ: assert property (!scan_en |=> !lp_clk_req)
        else $error("clock request while disabled");
    AST_IDLE_COLS: assert property (!scan_busy |-> &col_out)
        else $error("idle columns not all high");
    AST_SCAN_COLS: assert property (scan_busy |-> $onehot0(col_out) || &col_out)
        else $error("several columns driven while scanning");
    AST_START_REQ: assert property ($rose(scan_busy) |-> lp_clk_req)
        else $error("scan started without clock request");
    AST_END_DROP: assert property ($fell(scan_busy) |-> !lp_clk_req)
        else $error("request kept after return to idle");
    AST_GHOST_HOLD: assert property (ghost_flag && !ghost_clr |=> ghost_flag)
        else $error("ghost flag lost without clear");
    AST_GHOST_CLR: assert property (ghost_clr && !scan_busy |=> !ghost_flag)
        else $error("ghost flag not cleared");
    AST_OVF_HOLD: assert property (ovf_flag && !ovf_clr |=> ovf_flag)
        else $error("overflow flag lost without clear");
    AST_OVF_CLR: assert property (ovf_clr && !scan_busy |=> !ovf_flag)
        else $error("overflow flag not cleared");
    AST_MOD_IDLE: assert property (!scan_busy |-> mod_state == '0)
        else $error("modifier state set while idle");

    cover property ($rose(scan_busy));
    cover property ($rose(ghost_flag));
    cover property ($rose(ovf_flag));
    cover property (key_valid && key_pop);
endmodule

bind key_scanner scanner_checker #(.NMOD(NMOD), .DEPTH(DEPTH)) scanner_checker_i (
    .mclk(mclk), .nrst(nrst), .scan_en(scan_en), .col_out(col_out),
    .lp_clk_req(lp_clk_req), .key_valid(key_valid), .key_pop(key_pop),
    .scan_busy(scan_busy), .ghost_flag(ghost_flag), .ghost_clr(ghost_clr),
    .ovf_flag(ovf_flag), .ovf_clr(ovf_clr), .mod_state(mod_state)
);

// ===== bench/key_matrix.sv
// behavioural key switch matrix, a closed key ties its row to its column
module key_matrix (
    // column drive
    input wire logic [19:0] col_out,
    // closed keys, rows per column
    input wire logic [19:0][7:0] pressed,
    // row sense lines
    output logic [7:0] row_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // open rows sit at the pull-down level, so no stale value lingers
    always_comb begin
        row_in = 8'h00;
        for (int c = 0; c < 20; c++) begin
            row_in = row_in | (pressed[c] & {8{col_out[c]}});
        end
    end
endmodule

// ===== bench/testbench.sv
// self-checking bench for the key matrix scanner
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import kscan_pkg::*;

    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic scan_en = 1'b0;
    logic key_pop = 1'b0;
    logic ghost_clr = 1'b0;
    logic ovf_clr = 1'b0;
    logic [4:0] num_cols = 5'h03;
    logic [3:0] num_rows = 4'h2;
    logic [7:0][7:0] mod_code = {8{8'hff}};
    logic [19:0][7:0] pressed = '0;
    logic [7:0] row_in;
    logic [19:0] col_out;
    logic [7:0] key_code;
    logic [7:0] mod_state;
    logic lp_clk_req, key_valid, scan_busy, ghost_flag, ovf_flag;
    int errors = 0;
    int checks = 0;

    always #20 mclk = ~mclk;

    key_matrix key_matrix_i (.col_out(col_out), .pressed(pressed), .row_in(row_in));
    key_scanner key_scanner_i (
        .mclk(mclk), .nrst(nrst), .scan_en(scan_en), .num_cols(num_cols),
        .num_rows(num_rows), .mod_code(mod_code), .row_in(row_in), .col_out(col_out),
        .lp_clk_req(lp_clk_req), .key_valid(key_valid), .key_pop(key_pop),
        .key_code(key_code), .scan_busy(scan_busy), .ghost_flag(ghost_flag),
        .ghost_clr(ghost_clr), .ovf_flag(ovf_flag), .ovf_clr(ovf_clr),
        .mod_state(mod_state)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic sel(input int k);
        case (k)
            0: return scan_busy;
            1: return key_valid;
            2: return ghost_flag;
            4: return mod_state[0];
            default: return lp_clk_req;
        endcase
    endfunction

    // polled wait, bounded so a stuck scanner cannot hang the run
    task automatic wait_sig(input int k, input logic v, input int n);
        for (int i = 0; i < n && sel(k) !== v; i++) begin
            @(negedge mclk);
        end
        chk(32'(sel(k)), 32'(v));
    endtask

    task automatic pop_chk(input logic [7:0] exp);
        chk(32'(key_valid), 32'h1);
        chk(32'(key_code), 32'(exp));
        key_pop = 1'b1;
        @(negedge mclk);
        key_pop = 1'b0;
        @(negedge mclk);
    endtask

    task automatic end_of_test;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge mclk);
        errors++;
        end_of_test;
    end

    initial begin
        mod_code[0] = 8'h05;
        repeat (10) @(negedge mclk);
        chk(32'(col_out), 32'h000fffff);
        chk(32'({lp_clk_req, key_valid, scan_busy, ghost_flag, ovf_flag}), 32'h0);
        nrst = 1'b1;
        pressed[0][0] = 1'b1;
        repeat (400) @(negedge mclk);
        chk(32'({lp_clk_req, scan_busy}), 32'h0);
        pressed[0][0] = 1'b0;
        repeat (200) @(negedge mclk);
        scan_en = 1'b1;
        repeat (5) @(negedge mclk);
        pressed[1][1] = 1'b1;
        wait_sig(3, 1'b1, 300);
        chk(32'(col_out), 32'h00000001);
        wait_sig(1, 1'b1, 3000);
        pop_chk(8'h03);
        pressed[1][1] = 1'b0;
        wait_sig(0, 1'b0, 6000);
        chk(32'(lp_clk_req), 32'h0);
        chk(32'(col_out), 32'h000fffff);
        // modifier index 5 sits at column 2, row 1
        pressed[2][1] = 1'b1;
        wait_sig(4, 1'b1, 5000);
        chk(32'(key_valid), 32'h0);
        pressed[2][1] = 1'b0;
        wait_sig(0, 1'b0, 6000);
        chk(32'(mod_state), 32'h0);
        pressed[0] = 8'h03;
        pressed[1] = 8'h01;
        wait_sig(2, 1'b1, 5000);
        pop_chk(8'h00);
        pop_chk(8'h01);
        chk(32'(key_valid), 32'h0);
        pressed[0] = 8'h00;
        pressed[1] = 8'h00;
        wait_sig(0, 1'b0, 6000);
        chk(32'(ghost_flag), 32'h1);
        ghost_clr = 1'b1;
        @(negedge mclk);
        ghost_clr = 1'b0;
        chk(32'(ghost_flag), 32'h0);
        pressed[1] = 8'h01;
        wait_sig(1, 1'b1, 5000);
        pop_chk(8'h02);
        chk(32'(ghost_flag), 32'h0);
        pressed[1] = 8'h00;
        wait_sig(0, 1'b0, 6000);
        // one row, two columns: a short pass, so refills are quick
        num_cols = 5'h02;
        num_rows = 4'h1;
        for (int i = 0; i < 17; i++) begin
            pressed[0][0] = 1'b1;
            repeat (1000) @(negedge mclk);
            pressed[0][0] = 1'b0;
            repeat (1000) @(negedge mclk);
            if (i == 15) chk(32'(ovf_flag), 32'h0);
        end
        chk(32'(ovf_flag), 32'h1);
        for (int i = 0; i < 16; i++) pop_chk(8'h00);
        chk(32'(key_valid), 32'h0);
        ovf_clr = 1'b1;
        @(negedge mclk);
        ovf_clr = 1'b0;
        chk(32'(ovf_flag), 32'h0);
        end_of_test;
    end
endmodule
